// ---- dpgio_pkg.sv ----
// Shared constants, types and decode helpers for the dual 8-bit GPIO block
package dpgio_pkg;

	localparam int unsigned DW = 8;
	localparam int unsigned AW = 7;
	localparam int unsigned BUS_W = 32;

	// Register indices; the byte address is four times the index
	localparam logic [4:0] IDX_EDGE_SEL = 5'h0c;
	localparam logic [4:0] IDX_PA_IE = 5'h0d;
	localparam logic [4:0] IDX_PB_IE = 5'h0e;
	localparam logic [4:0] IDX_PA_DATA = 5'h10;
	localparam logic [4:0] IDX_PA_DIR = 5'h11;
	localparam logic [4:0] IDX_PA_PU = 5'h12;
	localparam logic [4:0] IDX_PA_PD = 5'h13;
	localparam logic [4:0] IDX_PB_DATA = 5'h14;
	localparam logic [4:0] IDX_PB_DIR = 5'h15;
	localparam logic [4:0] IDX_PB_PU = 5'h16;
	localparam logic [4:0] IDX_PB_PD = 5'h17;
	localparam logic [4:0] IDX_IRQ_STAT = 5'h18;
	localparam logic [4:0] IDX_IRQ_MASK = 5'h19;
	localparam logic [4:0] IDX_CLK_MODE = 5'h1a;

	// Reset values and implemented-bit masks
	localparam logic [7:0] GPIO_RST = 8'h00;
	localparam logic [7:0] PA_IE_RST = 8'hf9;
	localparam logic [7:0] PA_IE_MASK = 8'hf9;
	localparam logic [7:0] PB_IE_RST = 8'h81;
	localparam logic [7:0] PB_IE_MASK = 8'h81;
	localparam logic [3:0] EDGE_RST = 4'h0;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [0:0] CLK_MODE_RST = 1'h0;

	// Field positions
	localparam int unsigned EDGE_PA0_LSB = 0;
	localparam int unsigned EDGE_PB0_LSB = 2;
	localparam int unsigned PIN_PA_IRQ = 0;
	localparam int unsigned PIN_PB_IRQ = 0;
	localparam int unsigned PIN_EXT_RST = 5;
	localparam int unsigned PIN_PB_SEVEN = 7;
	localparam int unsigned IRQ_PA0 = 0;
	localparam int unsigned IRQ_PB0 = 1;
	localparam int unsigned IRQ_WAKE = 2;
	localparam int unsigned IRQ_W = 3;

	// Sync depth of the pin synchroniser
	localparam int unsigned SYNC_STAGES = 2;

	typedef enum logic [1:0] {
		EDGE_BOTH = 2'b00,
		EDGE_RISE = 2'b01,
		EDGE_FALL = 2'b10,
		EDGE_RSVD = 2'b11
	} dpgio_edge_t;

	typedef enum logic {
		BUS_IDLE = 1'b0,
		BUS_ACK = 1'b1
	} dpgio_bus_t;

	// Pad controls of one port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
		logic [7:0] pu;
		logic [7:0] pd;
	} dpgio_pad_t;

	// Edge match for a given select code; reserved code never matches
	function automatic logic edge_hit(input logic prev, input logic cur, input dpgio_edge_t sel);
		logic rise;
		logic fall;
		rise = ~prev & cur;
		fall = prev & ~cur;
		case (sel)
			EDGE_BOTH: edge_hit = rise | fall;
			EDGE_RISE: edge_hit = rise;
			EDGE_FALL: edge_hit = fall;
			default: edge_hit = 1'b0;
		endcase
	endfunction : edge_hit

endpackage : dpgio_pkg

// ---- dpgio_sync.sv ----
// Two-flop synchroniser for pad inputs
`timescale 1ns/1ns
`default_nettype none
module dpgio_sync #(
	parameter int unsigned W = 8
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Data
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);

	logic [W-1:0] meta;

	// First stage feeds only the second
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			meta <= '0;
			sync_o <= '0;
		end
		else
		begin
			meta <= async_i;
			sync_o <= meta;
		end
	end

	a_sync_two_stage: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		$past(arst_n_i, 2) |-> sync_o == $past(async_i, 2))
		else $error("pin synchroniser latency is not two cycles");

endmodule : dpgio_sync
`default_nettype wire

// ---- dpgio_edge_det.sv ----
// Selectable edge detector for one external interrupt pin
`timescale 1ns/1ns
`default_nettype none
module dpgio_edge_det (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Pin level, already synchronised, and its controls
	input wire logic level_i,
	input wire logic enable_i,
	input wire dpgio_pkg::dpgio_edge_t sel_i,
	// Event pulse
	output logic event_o
);

	logic prev;

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			prev <= 1'b0;
			event_o <= 1'b0;
		end
		else
		begin
			prev <= level_i;
			event_o <= enable_i & dpgio_pkg::edge_hit(prev, level_i, sel_i);
		end
	end

	a_edge_rise_code: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(enable_i && sel_i == dpgio_pkg::EDGE_RISE && !prev && level_i) |=> event_o)
		else $error("rising edge with code 01 gave no event");

	a_edge_fall_code: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(sel_i == dpgio_pkg::EDGE_FALL && !(prev && !level_i)) |=> !event_o)
		else $error("code 10 gave an event without a falling edge");

endmodule : dpgio_edge_det
`default_nettype wire

// ---- dpgio_top.sv ----
// Dual 8-bit GPIO port with Avalon-MM register slave, wake-up and pin interrupts
//
// What this block does
// - Port B input-enable bit 7 enables input and wake-up on port B pin seven, resets to 1, write-only.
// - Port B input-enable bit 0 gates input, wake-up and interrupt of port B pin zero, resets to 1.
// - Each port has an 8-bit read/write output data register, reset 0x00, driving output pins.
// - Each port has an 8-bit direction register, reset 0x00, 0 input and 1 output.
// - Each port has an 8-bit pull-up enable register, reset 0x00, 1 turns the pull-up on.
// - Each port has an 8-bit pull-down enable register, reset 0x00, 1 turns the pull-down on.
// - An input pin may have pull-up and pull-down in any combination, and floats with neither.
// - A pin driving low has both pulls forced off whatever their enable bits say.
// - Reading a data register returns the stored bit, not the pad, for every output pin.
// - In power-down a toggle on an input pin with input enabled wakes the system.
// - Clock mode bit 0 turns port A pin five, as input, into the external reset input.
// - A build option selects normal or strong drive for some pins.
// - Edge select codes are 00 both edges, 01 rising, 10 falling, 11 reserved.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module dpgio_top #(
	parameter logic [7:0] STRONG_DRIVE_A = 8'h00,
	parameter logic [7:0] STRONG_DRIVE_B = 8'h00
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Avalon-MM slave
	input wire logic [dpgio_pkg::AW-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [dpgio_pkg::BUS_W-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [dpgio_pkg::BUS_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Pads
	input wire logic [7:0] pad_a_i,
	input wire logic [7:0] pad_b_i,
	output var dpgio_pkg::dpgio_pad_t pad_a_o,
	output var dpgio_pkg::dpgio_pad_t pad_b_o,
	output logic [7:0] strong_a_o,
	output logic [7:0] strong_b_o,
	// System
	input wire logic power_down_i,
	output logic wake_o,
	output logic ext_reset_o,
	output logic irq_o
);

	dpgio_pkg::dpgio_bus_t bus_state;
	logic [7:0] pa_data;
	logic [7:0] pa_dir;
	logic [7:0] pa_pu;
	logic [7:0] pa_pd;
	logic [7:0] pb_data;
	logic [7:0] pb_dir;
	logic [7:0] pb_pu;
	logic [7:0] pb_pd;
	logic [7:0] pa_ie;
	logic [7:0] pb_ie;
	logic [3:0] edge_sel;
	logic [0:0] clk_mode;
	logic [dpgio_pkg::IRQ_W-1:0] irq_stat;
	logic [dpgio_pkg::IRQ_W-1:0] irq_mask;
	logic [7:0] pa_sync;
	logic [7:0] pb_sync;
	logic [7:0] pa_prev;
	logic [7:0] pb_prev;
	logic [7:0] pa_ie_eff;
	logic [7:0] pb_ie_eff;
	logic [7:0] pa_rd;
	logic [7:0] pb_rd;
	logic [4:0] idx;
	logic aligned;
	logic req;
	logic take;
	logic wr_en;
	logic wake_hit;
	logic pa0_evt;
	logic pb0_evt;
	logic [dpgio_pkg::IRQ_W-1:0] irq_set;
	logic [dpgio_pkg::IRQ_W-1:0] irq_clr;
	logic [dpgio_pkg::BUS_W-1:0] next_rdata;

	// Pad inputs
	dpgio_sync #(
		.W(8)
	) u_sync_a (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.async_i(pad_a_i),
		.sync_o(pa_sync)
	);

	dpgio_sync #(
		.W(8)
	) u_sync_b (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.async_i(pad_b_i),
		.sync_o(pb_sync)
	);

	// Bus handshake: one wait cycle, then the request is taken
	assign req = avs_read_i | avs_write_i;
	assign idx = avs_address_i[6:2];
	assign aligned = (avs_address_i[1:0] == 2'b00);
	assign avs_waitrequest_o = req & (bus_state == dpgio_pkg::BUS_IDLE);
	assign take = req & (bus_state == dpgio_pkg::BUS_ACK);
	assign wr_en = take & avs_write_i & aligned & avs_byteenable_i[0];

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			bus_state <= dpgio_pkg::BUS_IDLE;
		end
		else
		begin
			case (bus_state)
				dpgio_pkg::BUS_IDLE: bus_state <= req ? dpgio_pkg::BUS_ACK : dpgio_pkg::BUS_IDLE;
				dpgio_pkg::BUS_ACK: bus_state <= dpgio_pkg::BUS_IDLE;
				default: bus_state <= dpgio_pkg::BUS_IDLE;
			endcase
		end
	end

	// Port configuration registers
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_data <= dpgio_pkg::GPIO_RST;
			pa_dir <= dpgio_pkg::GPIO_RST;
			pa_pu <= dpgio_pkg::GPIO_RST;
			pa_pd <= dpgio_pkg::GPIO_RST;
			pb_data <= dpgio_pkg::GPIO_RST;
			pb_dir <= dpgio_pkg::GPIO_RST;
			pb_pu <= dpgio_pkg::GPIO_RST;
			pb_pd <= dpgio_pkg::GPIO_RST;
		end
		else if (wr_en)
		begin
			case (idx)
				dpgio_pkg::IDX_PA_DATA: pa_data <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PA_DIR: pa_dir <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PA_PU: pa_pu <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PA_PD: pa_pd <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PB_DATA: pb_data <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PB_DIR: pb_dir <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PB_PU: pb_pu <= avs_writedata_i[7:0];
				dpgio_pkg::IDX_PB_PD: pb_pd <= avs_writedata_i[7:0];
				default: ;
			endcase
		end
	end

	// Input enables, edge select and clock mode; reserved bits stay zero
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_ie <= dpgio_pkg::PA_IE_RST;
			pb_ie <= dpgio_pkg::PB_IE_RST;
			edge_sel <= dpgio_pkg::EDGE_RST;
			clk_mode <= dpgio_pkg::CLK_MODE_RST;
		end
		else if (wr_en)
		begin
			case (idx)
				dpgio_pkg::IDX_PA_IE: pa_ie <= avs_writedata_i[7:0] & dpgio_pkg::PA_IE_MASK;
				dpgio_pkg::IDX_PB_IE: pb_ie <= avs_writedata_i[7:0] & dpgio_pkg::PB_IE_MASK;
				dpgio_pkg::IDX_EDGE_SEL: edge_sel <= avs_writedata_i[3:0];
				dpgio_pkg::IDX_CLK_MODE: clk_mode <= avs_writedata_i[0:0];
				default: ;
			endcase
		end
	end

	// Reserved enable positions have no gate, so those pins stay enabled
	assign pa_ie_eff = pa_ie | ~dpgio_pkg::PA_IE_MASK;
	assign pb_ie_eff = pb_ie | ~dpgio_pkg::PB_IE_MASK;

	// Output pins read back their stored bit; disabled inputs read zero
	assign pa_rd = (pa_dir & pa_data) | (~pa_dir & pa_sync & pa_ie_eff);
	assign pb_rd = (pb_dir & pb_data) | (~pb_dir & pb_sync & pb_ie_eff);

	// Pad drive; pulls drop out only when the pin drives low
	always_comb
	begin
		pad_a_o.out = pa_data;
		pad_a_o.oe = pa_dir;
		pad_a_o.pu = pa_pu & ~(pa_dir & ~pa_data);
		pad_a_o.pd = pa_pd & ~(pa_dir & ~pa_data);
		pad_b_o.out = pb_data;
		pad_b_o.oe = pb_dir;
		pad_b_o.pu = pb_pu & ~(pb_dir & ~pb_data);
		pad_b_o.pd = pb_pd & ~(pb_dir & ~pb_data);
	end

	// Drive strength is fixed at build time
	assign strong_a_o = STRONG_DRIVE_A;
	assign strong_b_o = STRONG_DRIVE_B;

	// Read mux; write-only and unmapped words read as zero
	always_comb
	begin
		next_rdata = '0;
		if (aligned)
		begin
			case (idx)
				dpgio_pkg::IDX_PA_DATA: next_rdata[7:0] = pa_rd;
				dpgio_pkg::IDX_PA_DIR: next_rdata[7:0] = pa_dir;
				dpgio_pkg::IDX_PA_PU: next_rdata[7:0] = pa_pu;
				dpgio_pkg::IDX_PA_PD: next_rdata[7:0] = pa_pd;
				dpgio_pkg::IDX_PB_DATA: next_rdata[7:0] = pb_rd;
				dpgio_pkg::IDX_PB_DIR: next_rdata[7:0] = pb_dir;
				dpgio_pkg::IDX_PB_PU: next_rdata[7:0] = pb_pu;
				dpgio_pkg::IDX_PB_PD: next_rdata[7:0] = pb_pd;
				dpgio_pkg::IDX_IRQ_STAT: next_rdata[dpgio_pkg::IRQ_W-1:0] = irq_stat;
				dpgio_pkg::IDX_IRQ_MASK: next_rdata[dpgio_pkg::IRQ_W-1:0] = irq_mask;
				dpgio_pkg::IDX_CLK_MODE: next_rdata[0:0] = clk_mode;
				default: next_rdata = '0;
			endcase
		end
	end

	// Captured in the wait cycle, so it stands at the taking edge
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			avs_readdata_o <= '0;
		end
		else if (avs_read_i && bus_state == dpgio_pkg::BUS_IDLE)
		begin
			avs_readdata_o <= next_rdata;
		end
	end

	// Pin interrupt sources
	dpgio_edge_det u_edge_pa0 (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.level_i(pa_sync[dpgio_pkg::PIN_PA_IRQ]),
		.enable_i(pa_ie_eff[dpgio_pkg::PIN_PA_IRQ]),
		.sel_i(dpgio_pkg::dpgio_edge_t'(edge_sel[dpgio_pkg::EDGE_PA0_LSB +: 2])),
		.event_o(pa0_evt)
	);

	dpgio_edge_det u_edge_pb0 (
		.clk_sys_i(clk_sys_i),
		.arst_n_i(arst_n_i),
		.level_i(pb_sync[dpgio_pkg::PIN_PB_IRQ]),
		.enable_i(pb_ie_eff[dpgio_pkg::PIN_PB_IRQ]),
		.sel_i(dpgio_pkg::dpgio_edge_t'(edge_sel[dpgio_pkg::EDGE_PB0_LSB +: 2])),
		.event_o(pb0_evt)
	);

	// Wake on any toggle of an enabled input pin while powered down
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pa_prev <= 8'h00;
			pb_prev <= 8'h00;
		end
		else
		begin
			pa_prev <= pa_sync;
			pb_prev <= pb_sync;
		end
	end

	assign wake_hit = power_down_i &
		(|(((pa_prev ^ pa_sync) & ~pa_dir & pa_ie_eff) | ((pb_prev ^ pb_sync) & ~pb_dir & pb_ie_eff)));

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			wake_o <= 1'b0;
		end
		else
		begin
			wake_o <= wake_hit;
		end
	end

	// External reset: active-low level on the pin when enabled and input
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ext_reset_o <= 1'b0;
		end
		else
		begin
			ext_reset_o <= clk_mode[0] & ~pa_dir[dpgio_pkg::PIN_EXT_RST] &
				~pa_sync[dpgio_pkg::PIN_EXT_RST];
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	assign irq_set = {wake_hit, pb0_evt, pa0_evt};
	assign irq_clr = (wr_en && idx == dpgio_pkg::IDX_IRQ_STAT) ?
		avs_writedata_i[dpgio_pkg::IRQ_W-1:0] : '0;

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			irq_stat <= dpgio_pkg::IRQ_RST;
			irq_mask <= dpgio_pkg::IRQ_RST;
		end
		else
		begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_set;
			if (wr_en && idx == dpgio_pkg::IDX_IRQ_MASK)
			begin
				irq_mask <= avs_writedata_i[dpgio_pkg::IRQ_W-1:0];
			end
		end
	end

	assign irq_o = |(irq_stat & irq_mask);

	a_pb7_in_gate: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!pb_ie[dpgio_pkg::PIN_PB_SEVEN] && !pb_dir[dpgio_pkg::PIN_PB_SEVEN])
		|-> !pb_rd[dpgio_pkg::PIN_PB_SEVEN])
		else $error("disabled port B pin seven still reads its pad");
	a_pb0_irq_block: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!$past(pb_ie[dpgio_pkg::PIN_PB_IRQ]) |-> !pb0_evt)
		else $error("port B pin zero interrupt while input disabled");
	a_data_write_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_en && idx == dpgio_pkg::IDX_PA_DATA) |=> pad_a_o.out == $past(avs_writedata_i[7:0]))
		else $error("port A data write not driven to pads");
	a_dir_write_b: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(wr_en && idx == dpgio_pkg::IDX_PB_DIR) |=> pad_b_o.oe == $past(avs_writedata_i[7:0]))
		else $error("port B direction write not seen on output enables");
	a_input_pulls: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		!pa_dir[3] |-> (pad_a_o.pu[3] == pa_pu[3] && pad_a_o.pd[3] == pa_pd[3]))
		else $error("input pin pulls do not follow their enables");
	a_low_no_pull: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(((pad_b_o.pu | pad_b_o.pd) & pad_b_o.oe & ~pad_b_o.out) == 8'h00)
		&& (((pad_a_o.pu | pad_a_o.pd) & pad_a_o.oe & ~pad_a_o.out) == 8'h00))
		else $error("pull left on at a pin driving low");
	a_read_out_bit: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(take && avs_read_i && aligned && idx == dpgio_pkg::IDX_PA_DATA)
		|-> ((avs_readdata_o[7:0] ^ pa_data) & pa_dir) == 8'h00)
		else $error("output pin read returned pad instead of register");
	a_wake_toggle: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(power_down_i && !pb_dir[0] && pb_ie[0] && (pb_prev[0] != pb_sync[0])) |=> wake_o)
		else $error("enabled input toggle in power-down did not wake");
	a_ext_reset: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(!clk_mode[0]) |=> !ext_reset_o)
		else $error("external reset asserted while not enabled");
	a_ack_one_wait: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		(req && bus_state == dpgio_pkg::BUS_IDLE) |=> !avs_waitrequest_o)
		else $error("bus request not answered after one wait cycle");
	a_set_beats_clear: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
		irq_set[dpgio_pkg::IRQ_PA0] |=> irq_stat[dpgio_pkg::IRQ_PA0])
		else $error("status event lost");
endmodule : dpgio_top
`default_nettype wire

// ---- dpgio_pad_model.sv ----
// Board-side model of one 8-bit port: external drivers, pulls and floating pins
`timescale 1ns/1ns
`default_nettype none
module dpgio_pad_model (
	// Clock
	input wire logic clk_sys_i,
	// Pad controls from the block and board-level drivers
	input wire dpgio_pkg::dpgio_pad_t pad_ctl_i,
	input wire logic [7:0] ext_val_i,
	input wire logic [7:0] ext_en_i,
	// Sensed pad level
	output logic [7:0] level_o
);
	// A floating pin flips every cycle, so a stale level can never pass for a match
	logic [7:0] flt = 8'h00;
	always @(posedge clk_sys_i)
		flt <= ~flt;
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pad_ctl_i.oe[i])
				level_o[i] = pad_ctl_i.out[i];
			else if (ext_en_i[i])
				level_o[i] = ext_val_i[i];
			else if (pad_ctl_i.pu[i] != pad_ctl_i.pd[i])
				level_o[i] = pad_ctl_i.pu[i];
			else
				level_o[i] = flt[i];
		end
	end
endmodule : dpgio_pad_model
`default_nettype wire

// ---- dpgio_top_tb.sv ----
// Self-checking testbench for the dual GPIO block
`timescale 1ns/1ns
`default_nettype none
module dpgio_top_tb;
	localparam logic [7:0] STRONG_A = 8'h3c;
	localparam logic [7:0] STRONG_B = 8'hc3;
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic [6:0] address = 7'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] readdata;
	logic waitrequest;
	logic [7:0] pad_a;
	logic [7:0] pad_b;
	dpgio_pkg::dpgio_pad_t ctl_a;
	dpgio_pkg::dpgio_pad_t ctl_b;
	logic [7:0] strong_a;
	logic [7:0] strong_b;
	logic power_down = 1'b0;
	logic wake;
	logic ext_reset;
	logic irq;
	logic [7:0] ext_a = 8'h00;
	logic [7:0] ext_b = 8'h00;
	logic [7:0] ext_en_a = 8'hff;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	int wake_cnt = 0;
	int n0;

	dpgio_top #(.STRONG_DRIVE_A(STRONG_A), .STRONG_DRIVE_B(STRONG_B)) i_dut (
		.clk_sys_i(clk_sys), .arst_n_i(arst_n), .avs_address_i(address), .avs_read_i(read),
		.avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(4'h1),
		.avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest), .pad_a_i(pad_a),
		.pad_b_i(pad_b), .pad_a_o(ctl_a), .pad_b_o(ctl_b), .strong_a_o(strong_a),
		.strong_b_o(strong_b), .power_down_i(power_down), .wake_o(wake),
		.ext_reset_o(ext_reset), .irq_o(irq));
	dpgio_pad_model i_pads_a (.clk_sys_i(clk_sys), .pad_ctl_i(ctl_a), .ext_val_i(ext_a),
		.ext_en_i(ext_en_a), .level_o(pad_a));
	dpgio_pad_model i_pads_b (.clk_sys_i(clk_sys), .pad_ctl_i(ctl_b), .ext_val_i(ext_b),
		.ext_en_i(8'hff), .level_o(pad_b));

	always #4 clk_sys = ~clk_sys;

	task automatic summarize();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %0t %s: got %h exp %h", $time, msg, got, exp);
		end
	endtask : chk

	// Request held until waitrequest is sampled low at a rising edge; data taken there
	task automatic bus(input logic wr_en, input logic [6:0] a, input logic [7:0] d,
		output logic [31:0] q);
		address <= a;
		writedata <= {24'h0, d};
		write <= wr_en;
		read <= ~wr_en;
		@(posedge clk_sys);
		while (waitrequest !== 1'b0)
			@(posedge clk_sys);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		@(posedge clk_sys);
	endtask : bus

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string msg);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q, exp, msg);
	endtask : rd

	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : idle

	always @(negedge clk_sys)
		if (wake === 1'b1)
			wake_cnt++;

	// Tests finish in well under a thousand cycles
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			$display("BAD %0t timeout", $time);
			summarize();
		end
	end

	initial
	begin
		repeat (3) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		for (int i = 0; i < 8; i++)
			rd(7'h40 + 7'(4 * i), 32'h0, "reset value");
		rd(7'h38, 32'h0, "write-only enable");
		rd(7'h7c, 32'h0, "unmapped");
		chk({24'h0, strong_a}, {24'h0, STRONG_A}, "drive a");
		chk({24'h0, strong_b}, {24'h0, STRONG_B}, "drive b");
		chk({31'h0, waitrequest}, 32'h0, "idle wait");
		$display("test reset done");
		for (int i = 1; i < 8; i++)
		begin
			if (i != 4)
			begin
				wr(7'h40 + 7'(4 * i), 8'h5a + 8'(i));
				rd(7'h40 + 7'(4 * i), 32'h5a + 32'(i), "readback");
			end
		end
		chk(ctl_b, 32'h005f2020, "port b pads");
		$display("test access done");
		wr(7'h44, 8'hf0);
		wr(7'h40, 8'ha5);
		ext_a <= 8'h3c;
		idle(4);
		rd(7'h40, 32'hac, "mixed read");
		chk({24'h0, ctl_a.out}, 32'ha5, "out");
		chk({24'h0, ctl_a.oe}, 32'hf0, "oe");
		wr(7'h48, 8'hff);
		wr(7'h4c, 8'h0f);
		chk({24'h0, ctl_a.pu}, 32'haf, "pull-up");
		chk({24'h0, ctl_a.pd}, 32'h0f, "pull-down");
		wr(7'h4c, 8'h00);
		ext_en_a <= 8'h00;
		idle(4);
		rd(7'h40, 32'haf, "pulled read");
		ext_en_a <= 8'hff;
		idle(4);
		$display("test pads done");
		wr(7'h54, 8'h00);
		wr(7'h64, 8'h02);
		for (int c = 0; c < 4; c++)
		begin
			wr(7'h30, 8'(c << 2));
			wr(7'h60, 8'h07);
			ext_b[0] <= 1'b1;
			idle(6);
			rd(7'h60, (c < 2) ? 32'h2 : 32'h0, "rise");
			chk({31'h0, irq}, (c < 2) ? 32'h1 : 32'h0, "irq rise");
			wr(7'h60, 8'h07);
			ext_b[0] <= 1'b0;
			idle(6);
			rd(7'h60, (c == 0 || c == 2) ? 32'h2 : 32'h0, "fall");
		end
		wr(7'h30, 8'h00);
		wr(7'h64, 8'h00);
		wr(7'h60, 8'h07);
		ext_b[0] <= 1'b1;
		idle(6);
		rd(7'h60, 32'h2, "masked status");
		chk({31'h0, irq}, 32'h0, "masked irq");
		wr(7'h64, 8'h02);
		chk({31'h0, irq}, 32'h1, "unmasked irq");
		ext_b[0] <= 1'b0;
		idle(6);
		wr(7'h60, 8'h07);
		chk({31'h0, irq}, 32'h0, "cleared irq");
		wr(7'h38, 8'h80);
		ext_b[0] <= 1'b1;
		idle(6);
		rd(7'h60, 32'h0, "gated pin");
		ext_b[0] <= 1'b0;
		idle(6);
		wr(7'h38, 8'h81);
		wr(7'h30, 8'h01);
		wr(7'h64, 8'h01);
		wr(7'h60, 8'h07);
		ext_a[0] <= 1'b1;
		idle(6);
		rd(7'h60, 32'h1, "port a pin");
		chk({31'h0, irq}, 32'h1, "port a irq");
		wr(7'h64, 8'h00);
		$display("test interrupts done");
		wr(7'h60, 8'h07);
		power_down <= 1'b1;
		n0 = wake_cnt;
		ext_b[7] <= 1'b1;
		idle(6);
		chk(32'(wake_cnt - n0), 32'h1, "wake pulse");
		rd(7'h60, 32'h4, "wake status");
		wr(7'h38, 8'h01);
		idle(6);
		wr(7'h60, 8'h07);
		n0 = wake_cnt;
		ext_b[7] <= 1'b0;
		idle(6);
		chk(32'(wake_cnt - n0), 32'h0, "no wake");
		rd(7'h60, 32'h0, "no wake status");
		power_down <= 1'b0;
		$display("test wake done");
		wr(7'h44, 8'h00);
		wr(7'h68, 8'h01);
		idle(4);
		chk({31'h0, ext_reset}, 32'h0, "reset pin high");
		ext_a[5] <= 1'b0;
		idle(4);
		chk({31'h0, ext_reset}, 32'h1, "reset pin low");
		wr(7'h44, 8'h20);
		idle(2);
		chk({31'h0, ext_reset}, 32'h0, "reset pin output");
		$display("test external reset done");
		summarize();
	end
endmodule : dpgio_top_tb
`default_nettype wire
